// ---- mission_histogram_alarm_log.sv ----
// Histogram, threshold alarm, violation log and indicator pulse logic of a
// temperature and ADC datalogger during a logging mission.
// Assumes a serial front end issuing byte accesses, a converter issuing
// one sample per pulse, and an external 24-bit current sample counter.
//
// How it works
// - 63 temperature bins from 0800h to 087Ch
// - Bins are 16-bit, low byte lower address
// - 64 ADC1 bins, 0880h-08FFh, four codes each
// - Bin index is sample without two LSBs
// - Phantom 64th temperature bin always reads zero
// - Bins saturate at 65535, never wrap
// - Histograms update only during an active mission
// - Only temperature and ADC1 log violations
// - Strictly inside band raises no alarm
// - Temperature violation sets flag, starts log entry
// - Temperature flags drive interrupt when enabled
// - ADC1 violation flags, logs, interrupts when enabled
// - Time stamp copies 3-byte sample counter
// - Duration byte; new entry after 255 readings
// - Return to band ends entry; recrossing opens new
// - Four 24-byte regions of six records
// - Four pulses, 62.5 ms, every half second
// - Mission start pulses both indicators together
// - Status request pulses in-spec or out-of-spec
// - Before first sample: four alternating pulses, out first
// - Status request by command or held input
// - Clock or control write stops mission
// - Writing zero ends mission; one ignored
// - Temperature-low flag cleared only by zero write
`timescale 1ns/1ps
`include "mission_log_regs.svh"

module mission_histogram_alarm_log #(
  parameter int PULSE_CYCLES  = `PULSE_TIME_NS / `CLK_PERIOD_NS,
  parameter int PERIOD_CYCLES = `PERIOD_TIME_NS / `CLK_PERIOD_NS,
  parameter int HOLD_CYCLES   = `HOLD_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     nrst,
  // Register access from the serial front end
  input  wire mission_log_pkg::access_type access,
  output logic [7:0]                    read_data,
  // Conversion results and sample counter
  input  wire mission_log_pkg::sample_type sample,
  input  wire logic [23:0]              sample_counter,
  // Mission and status requests
  input  wire logic                     mission_start,
  input  wire logic                     spec_test_cmd,
  input  wire logic                     start_status_input,
  // Outputs
  output logic                          mission_active,
  output logic                          irq_n,
  output logic                          in_spec_indicator_n,
  output logic                          out_of_spec_indicator_n
);

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  logic [7:0]  temp_band_limit_a;
  logic [7:0]  temp_band_limit_b;
  logic [7:0]  adc_limit [6];
  logic [7:0]  control_one;
  logic [7:0]  control_two;
  logic        temp_high_flag;
  logic        temp_low_flag;
  logic [2:0]  adc_high_flag;
  logic [2:0]  adc_low_flag;
  logic [15:0] hist [128];
  logic [7:0]  rec_rd [4];
  logic        out_seen;
  logic        first_seen;

  wire logic [15:0] addr       = access.addr;
  wire logic        wr_status  = access.wr && addr == `STATUS_FLAGS;
  wire logic        wr_stat_adc = access.wr && addr == `STATUS_ADC;
  wire logic        wr_control = access.wr && addr <= `CTRL_REGION_LAST
                                 && !wr_status && !wr_stat_adc;
  wire logic        in_hist    = addr >= `HIST_REGION_FIRST && addr <= `HIST_REGION_LAST;
  wire logic        in_rec     = addr >= `REC_REGION_FIRST && addr <= `REC_REGION_LAST;
  wire logic [6:0]  rd_bin     = addr[7:1];
  wire logic [15:0] rec_ofs    = addr - `REC_REGION_FIRST;
  wire logic [1:0]  rd_cat     = 2'(rec_ofs / `REC_BYTES);
  wire logic [15:0] hist_word  = (rd_bin == `TEMP_BIN_PHANTOM) ? 16'h0000
                                 : hist[rd_bin];
  wire logic [7:0]  hist_byte  = addr[0] ? hist_word[15:8] : hist_word[7:0];
  wire logic        adc_window = addr >= `ADC_BAND_LIMIT_FIRST && addr <= `ADC_BAND_LIMIT_LAST;
  wire logic [2:0]  adc_idx    = 3'(addr - `ADC_BAND_LIMIT_FIRST);
  wire logic [7:0]  status_byte = {2'h0, mission_active, 2'h0, temp_low_flag,
                                   temp_high_flag, 1'h0};
  wire logic [7:0]  next_read_data =
      in_hist                          ? hist_byte :
      in_rec                           ? rec_rd[rd_cat] :
      addr == `TEMP_BAND_LIMIT_A       ? temp_band_limit_a :
      addr == `TEMP_BAND_LIMIT_B       ? temp_band_limit_b :
      addr == `CONTROL_ONE             ? control_one :
      addr == `CONTROL_TWO             ? control_two :
      addr == `STATUS_FLAGS            ? status_byte :
      addr == `STATUS_ADC              ? {2'h0, adc_high_flag, adc_low_flag} :
      adc_window                       ? adc_limit[adc_idx] : 8'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_data <= 8'h00;
    end else if (access.rd) begin
      read_data <= next_read_data;
    end
  end
  // Limit a is the low temperature threshold, b the high one
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      temp_band_limit_a <= `LIMIT_LOW_RESET;
      temp_band_limit_b <= `LIMIT_HIGH_RESET;
      control_one       <= 8'h00;
      control_two       <= 8'h00;
    end else if (access.wr) begin
      if (addr == `TEMP_BAND_LIMIT_A) temp_band_limit_a <= access.wdata;
      if (addr == `TEMP_BAND_LIMIT_B) temp_band_limit_b <= access.wdata;
      if (addr == `CONTROL_ONE) control_one <= access.wdata;
      if (addr == `CONTROL_TWO) control_two <= access.wdata;
    end
  end
  // Even entries are low limits, odd entries high limits, per ADC channel
  for (genvar i = 0; i < 6; i++) begin : g_adc_limit
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        adc_limit[i] <= (i % 2 == 0) ? `LIMIT_LOW_RESET : `LIMIT_HIGH_RESET;
      end else if (access.wr && adc_window && adc_idx == 3'(i)) begin
        adc_limit[i] <= access.wdata;
      end
    end
  end

  // ****************************************************************
  // Threshold comparison and flags
  // ****************************************************************
  wire logic       live       = sample.valid && mission_active;
  wire logic       is_temp    = sample.chan == 2'h0;
  wire logic [1:0] adc_ch     = 2'(sample.chan - 2'h1);
  wire logic [7:0] cur_low    = is_temp ? temp_band_limit_a : adc_limit[{adc_ch, 1'b0}];
  wire logic [7:0] cur_high   = is_temp ? temp_band_limit_b : adc_limit[{adc_ch, 1'b1}];
  wire logic       below      = sample.value <= cur_low;
  wire logic       above      = sample.value >= cur_high;
  wire logic       adc_enabled = control_two[sample.chan];
  wire logic [3:0] cat_hit    = {live && !is_temp && adc_ch == 2'h0,
                                 live && !is_temp && adc_ch == 2'h0,
                                 live && is_temp, live && is_temp};
  wire logic [3:0] cat_viol   = {above, below, above, below};
  wire logic [2:0] adc_hi_set = {3{live && !is_temp && above}} & (3'h1 << adc_ch);
  wire logic [2:0] adc_lo_set = {3{live && !is_temp && below}} & (3'h1 << adc_ch);
  wire logic       temp_irq   = (temp_high_flag && control_one[`TEMP_HIGH_IRQ_ENABLE_BIT]) ||
                                (temp_low_flag && control_one[`TEMP_LOW_IRQ_ENABLE_BIT]);
  wire logic       adc_irq    = (|adc_high_flag && control_two[4 + `ADC_HIGH_IRQ_ENABLE_BIT]) ||
                                (|adc_low_flag && control_two[4 + `ADC_LOW_IRQ_ENABLE_BIT]);
  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      temp_high_flag <= 1'b0;
      temp_low_flag  <= 1'b0;
      adc_high_flag  <= 3'h0;
      adc_low_flag   <= 3'h0;
      irq_n          <= 1'b1;
    end else begin
      temp_high_flag <= (live && is_temp && above) ||
                        (temp_high_flag && !(wr_status && !access.wdata[`THF_BIT]));
      temp_low_flag  <= (live && is_temp && below) ||
                        (temp_low_flag && !(wr_status && !access.wdata[`TLF_BIT]));
      adc_high_flag  <= adc_hi_set |
                        (adc_high_flag & ~({3{wr_stat_adc}} & ~access.wdata[5:3]));
      adc_low_flag   <= adc_lo_set |
                        (adc_low_flag & ~({3{wr_stat_adc}} & ~access.wdata[2:0]));
      irq_n          <= !(temp_irq || adc_irq);
    end
  end
  // Mission state, out-of-band history and first-sample marker
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mission_active <= 1'b0;
      out_seen       <= 1'b0;
      first_seen     <= 1'b0;
    end else if (mission_start) begin
      mission_active <= 1'b1;
      out_seen       <= 1'b0;
      first_seen     <= 1'b0;
    end else begin
      if (wr_control || (wr_status && !access.wdata[`MIP_BIT])) begin
        mission_active <= 1'b0;
      end
      if (live) begin
        first_seen <= 1'b1;
        if ((above || below) && (is_temp || adc_enabled)) out_seen <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Histograms
  // ****************************************************************
  // Temperature bins 0..63, ADC1 bins 64..127; bin 63 is storage only
  wire logic [6:0]  bin_idx  = {!is_temp, sample.value[7:2]};
  wire logic        hist_upd = live && (is_temp || adc_ch == 2'h0);
  wire logic [15:0] bin_cur  = hist[bin_idx];
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int b = 0; b < 128; b++) hist[b] <= 16'h0000;
    end else if (hist_upd && bin_cur != `BIN_MAX) begin
      hist[bin_idx] <= bin_cur + 16'h0001;
    end
  end

  // ****************************************************************
  // Violation records: low temp, high temp, low ADC1, high ADC1
  // ****************************************************************
  for (genvar c = 0; c < 4; c++) begin : g_rec
    logic [7:0] rec [`REC_BYTES];
    logic [2:0] used;
    logic [7:0] dur;
    logic       open_run;
    logic       rec_ok;
    wire logic       viol  = cat_hit[c] && cat_viol[c];
    wire logic       start = viol && (!open_run || dur == `DUR_MAX);
    wire logic       room  = used < `REC_SLOTS;
    wire logic [4:0] base  = 5'(used * `REC_SLOT_BYTES);
    wire logic [4:0] cur   = 5'((used - 3'h1) * `REC_SLOT_BYTES + `REC_DUR_OFS);
    wire logic [4:0] rd_ix = 5'(rec_ofs - 16'(c * `REC_BYTES));
    assign rec_rd[c] = rec[rd_ix];

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        used     <= 3'h0;
        dur      <= 8'h00;
        open_run <= 1'b0;
        rec_ok   <= 1'b0;
      end else if (mission_start) begin
        used     <= 3'h0;
        open_run <= 1'b0;
        rec_ok   <= 1'b0;
      end else if (cat_hit[c]) begin
        open_run <= viol;
        if (start) begin
          dur    <= 8'h01;
          rec_ok <= room;
          if (room) used <= used + 3'h1;
        end else if (viol) begin
          dur <= dur + 8'h01;
        end
      end
    end
    // Record bytes have no reset: they behave as memory
    always_ff @(posedge clock) begin
      if (!mission_start && start && room) begin
        rec[base]        <= sample_counter[7:0];
        rec[base + 5'h1] <= sample_counter[15:8];
        rec[base + 5'h2] <= sample_counter[23:16];
        rec[base + 5'h3] <= 8'h01;
      end else if (!mission_start && viol && !start && rec_ok) begin
        rec[cur] <= dur + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Start/status input and status requests
  // ****************************************************************
  logic        st_s1;
  logic        st_s2;
  logic        st_s3;
  logic        st_level;
  logic [31:0] hold_cnt;
  wire logic   hold_done = !st_level && hold_cnt == 32'(HOLD_CYCLES - 1);
  wire logic   status_req = (spec_test_cmd || hold_done) && mission_active;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_s1    <= 1'b1;
      st_s2    <= 1'b1;
      st_s3    <= 1'b1;
      st_level <= 1'b1;
      hold_cnt <= 32'h0;
    end else begin
      st_s1 <= start_status_input;
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      if (st_s2 == st_s3) st_level <= st_s3;
      if (st_level) hold_cnt <= 32'h0;
      else if (hold_cnt != 32'(HOLD_CYCLES)) hold_cnt <= hold_cnt + 32'h1;
    end
  end

  // ****************************************************************
  // Indicator pulse sequencer
  // ****************************************************************
  // Requests arriving while a sequence runs are dropped
  mission_log_pkg::ind_mode_type mode;
  logic [31:0] timer;
  logic [1:0]  pulse_no;
  wire logic   pulse_on = timer < 32'(PULSE_CYCLES);
  wire logic   last_tick = timer == 32'(PERIOD_CYCLES - 1);
  wire logic   ind_idle = mode == mission_log_pkg::IND_IDLE;
  wire logic   drive_in = pulse_on && (mode == mission_log_pkg::IND_BOTH ||
                          mode == mission_log_pkg::IND_IN ||
                          (mode == mission_log_pkg::IND_ALT && pulse_no[0]));
  wire logic   drive_out = pulse_on && (mode == mission_log_pkg::IND_BOTH ||
                          mode == mission_log_pkg::IND_OUT ||
                          (mode == mission_log_pkg::IND_ALT && !pulse_no[0]));
  wire mission_log_pkg::ind_mode_type req_mode =
      !first_seen ? mission_log_pkg::IND_ALT :
      out_seen    ? mission_log_pkg::IND_OUT : mission_log_pkg::IND_IN;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode     <= mission_log_pkg::IND_IDLE;
      timer    <= 32'h0;
      pulse_no <= 2'h0;
    end else if (ind_idle && mission_start) begin
      mode     <= mission_log_pkg::IND_BOTH;
      timer    <= 32'h0;
      pulse_no <= 2'h0;
    end else if (ind_idle && status_req) begin
      mode     <= req_mode;
      timer    <= 32'h0;
      pulse_no <= 2'h0;
    end else if (!ind_idle) begin
      timer <= last_tick ? 32'h0 : timer + 32'h1;
      if (last_tick) begin
        pulse_no <= pulse_no + 2'h1;
        if (pulse_no == `PULSE_COUNT) mode <= mission_log_pkg::IND_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_spec_indicator_n     <= 1'b1;
      out_of_spec_indicator_n <= 1'b1;
    end else begin
      in_spec_indicator_n     <= !(!ind_idle && drive_in);
      out_of_spec_indicator_n <= !(!ind_idle && drive_out);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_hist_inc;
    @(posedge clock) disable iff (!nrst)
    hist_upd && bin_cur != `BIN_MAX |=> hist[$past(bin_idx)] == $past(bin_cur) + 16'h0001;
  endproperty
  a_hist_inc: assert property (p_hist_inc) else $error("bin did not count");
  property p_hist_sat;
    @(posedge clock) disable iff (!nrst)
    hist_upd && bin_cur == `BIN_MAX |=> hist[$past(bin_idx)] == `BIN_MAX;
  endproperty
  a_hist_sat: assert property (p_hist_sat) else $error("bin wrapped");
  property p_hist_idle;
    @(posedge clock) disable iff (!nrst)
    sample.valid && !mission_active |=> hist[$past(bin_idx)] == $past(bin_cur);
  endproperty
  a_hist_idle: assert property (p_hist_idle) else $error("bin moved outside mission");
  property p_phantom;
    @(posedge clock) disable iff (!nrst)
    access.rd && in_hist && rd_bin == `TEMP_BIN_PHANTOM |=> read_data == 8'h00;
  endproperty
  a_phantom: assert property (p_phantom) else $error("phantom bin not zero");
  property p_temp_low;
    @(posedge clock) disable iff (!nrst)
    live && is_temp && sample.value <= temp_band_limit_a |=> temp_low_flag;
  endproperty
  a_temp_low: assert property (p_temp_low) else $error("low flag not set");
  property p_irq;
    @(posedge clock) disable iff (!nrst)
    (temp_high_flag && control_one[`TEMP_HIGH_IRQ_ENABLE_BIT]) ||
    (temp_low_flag && control_one[`TEMP_LOW_IRQ_ENABLE_BIT]) |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not asserted");
  property p_ctrl_stop;
    @(posedge clock) disable iff (!nrst)
    wr_control && !mission_start |=> !mission_active;
  endproperty
  a_ctrl_stop: assert property (p_ctrl_stop) else $error("mission kept running");
  property p_mip_one;
    @(posedge clock) disable iff (!nrst)
    !mission_active && wr_status && !mission_start |=> !mission_active;
  endproperty
  a_mip_one: assert property (p_mip_one) else $error("mission set by write");
  property p_start_both;
    @(posedge clock) disable iff (!nrst)
    ind_idle && mission_start |=> ##1 !in_spec_indicator_n && !out_of_spec_indicator_n;
  endproperty
  a_start_both: assert property (p_start_both) else $error("start pulses missing");
  c_mission: cover property (@(posedge clock) disable iff (!nrst)
    mission_start ##1 mission_active);
  c_status: cover property (@(posedge clock) disable iff (!nrst)
    ind_idle && status_req);
  c_long_run: cover property (@(posedge clock) disable iff (!nrst)
    g_rec[0].viol && g_rec[0].dur == `DUR_MAX);

endmodule : mission_histogram_alarm_log

// ---- mission_log_regs.svh ----
// Register offsets, field positions, reset values and timing figures of the
// mission histogram and alarm log block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MISSION_LOG_REGS_SVH
`define MISSION_LOG_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TEMP_BAND_LIMIT_A   16'h000B
`define TEMP_BAND_LIMIT_B   16'h000C
`define CONTROL_ONE         16'h000E
`define CONTROL_TWO         16'h000F
`define STATUS_FLAGS        16'h0014
`define STATUS_ADC          16'h0015
`define ADC_BAND_LIMIT_FIRST 16'h0024
`define ADC_BAND_LIMIT_LAST 16'h0029
`define CTRL_REGION_LAST    16'h001F
`define REC_REGION_FIRST    16'h0220
`define REC_REGION_LAST     16'h027F
`define HIST_REGION_FIRST   16'h0800
`define HIST_REGION_LAST    16'h08FF
`define TEMP_BIN_PHANTOM    7'h3F

// ****************************************************************
// Field positions
// ****************************************************************
`define MIP_BIT             5
`define TLF_BIT             2
`define THF_BIT             1
`define TEMP_LOW_IRQ_ENABLE_BIT            2
`define TEMP_HIGH_IRQ_ENABLE_BIT            1
`define ADC_LOW_IRQ_ENABLE_BIT            1
`define ADC_HIGH_IRQ_ENABLE_BIT            0

// ****************************************************************
// Reset values and record layout
// ****************************************************************
`define LIMIT_LOW_RESET     8'h00
`define LIMIT_HIGH_RESET    8'hFF
`define BIN_MAX             16'hFFFF
`define DUR_MAX             8'hFF
`define REC_SLOTS           3'h6
`define REC_BYTES           24
`define REC_SLOT_BYTES      5'h04
`define REC_DUR_OFS         5'h03
`define PULSE_COUNT         2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS       4
`define PULSE_TIME_NS       62500000
`define PERIOD_TIME_NS      500000000
`define HOLD_TIME_NS        500000000

`endif

// ---- mission_log_pkg.sv ----
// Types shared by the mission histogram and alarm log block.
// Assumes mission_log_regs.svh for all numeric constants.
`include "mission_log_regs.svh"

package mission_log_pkg;

  // Byte access from the serial interface front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } access_type;

  // One completed conversion: 0 temperature, 1..3 ADC channels
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [7:0] value;
  } sample_type;

  typedef enum logic [2:0] {
    IND_IDLE,
    IND_BOTH,
    IND_IN,
    IND_OUT,
    IND_ALT
  } ind_mode_type;

endpackage : mission_log_pkg

// ---- indicator_watch.sv ----
// Model of the two indicator LEDs: counts low pulses of both, measures low width of the out-of-spec LED only.
// Assumes active-low indicator pins sampled on the block's clock.
`timescale 1ns/1ps
module indicator_watch (
  // Clock and pins
  input wire logic clock,
  input wire logic in_n,
  input wire logic out_n
);
  int   in_pulses  = 0;
  int   out_pulses = 0;
  int   low_run    = 0;
  int   out_width  = 0;
  logic in_q       = 1'b1;
  logic out_q      = 1'b1;
  // LEDs only watch; a pulse counts on its falling edge
  always @(posedge clock) begin
    in_q <= in_n;
    out_q <= out_n;
    if (in_q && !in_n) in_pulses <= in_pulses + 1;
    if (out_q && !out_n) out_pulses <= out_pulses + 1;
    low_run <= out_n ? 0 : low_run + 1;
    if (!out_q && out_n) out_width <= low_run;
  end
endmodule : indicator_watch

// ---- mission_histogram_alarm_log_tb_top.sv ----
// Self-checking bench of the mission histogram and alarm log block.
// Assumes shortened pulse, period and hold counts set below.
`timescale 1ns/1ps
module mission_histogram_alarm_log_tb_top;
  localparam int PERIOD = 16;
  logic                        clock = 1'b0;
  logic                        nrst = 1'b0;
  mission_log_pkg::access_type access = '0;
  mission_log_pkg::sample_type sample = '0;
  logic [23:0]                 sample_counter = 24'h123456;
  logic                        mission_start = 1'b0;
  logic                        spec_test_cmd = 1'b0;
  logic                        start_status_input = 1'b1;
  logic [7:0]                  read_data;
  logic                        mission_active;
  logic                        irq_n;
  logic                        in_n;
  logic                        out_n;
  int                          miscompares = 0;
  int                          comparisons = 0;
  int                          base_in;
  int                          base_out;
  always #2 clock = ~clock;
  mission_histogram_alarm_log #(.PULSE_CYCLES(4), .PERIOD_CYCLES(PERIOD), .HOLD_CYCLES(8))
    u_mission_histogram_alarm_log (.clock(clock), .nrst(nrst), .access(access),
    .read_data(read_data), .sample(sample), .sample_counter(sample_counter),
    .mission_start(mission_start), .spec_test_cmd(spec_test_cmd),
    .start_status_input(start_status_input), .mission_active(mission_active),
    .irq_n(irq_n), .in_spec_indicator_n(in_n), .out_of_spec_indicator_n(out_n));
  indicator_watch u_indicator_watch (.clock(clock), .in_n(in_n), .out_n(out_n));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task wr(logic [15:0] a, logic [7:0] d);
    @(negedge clock) access = {1'b1, 1'b0, a, d};
    @(negedge clock) access = '0;
  endtask : wr
  task rd(logic [15:0] a, logic [7:0] e);
    @(negedge clock) access = {1'b0, 1'b1, a, 8'h00};
    @(negedge clock) access = '0;
    check($sformatf("byte %h", a), read_data, e);
  endtask : rd
  task smp(logic [1:0] c, logic [7:0] v);
    @(negedge clock) sample = {1'b1, c, v};
    @(negedge clock) sample = '0;
  endtask : smp
  // Which: 0 start, 1 command, 2 held input
  task request(int which, int e_in, int e_out);
    base_in = u_indicator_watch.in_pulses;
    base_out = u_indicator_watch.out_pulses;
    @(negedge clock);
    if (which == 0) mission_start = 1'b1;
    if (which == 1) spec_test_cmd = 1'b1;
    if (which == 2) start_status_input = 1'b0;
    repeat ((which == 2) ? 14 : 1) @(negedge clock);
    mission_start = 1'b0;
    spec_test_cmd = 1'b0;
    start_status_input = 1'b1;
    repeat (4 * PERIOD + 8) @(negedge clock);
    check("in pulses", u_indicator_watch.in_pulses - base_in, e_in);
    check("out pulses", u_indicator_watch.out_pulses - base_out, e_out);
    check("pulse width", u_indicator_watch.out_width, 4);
  endtask : request
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task test_idle;
    rd(16'h000B, 8'h00);
    rd(16'h000C, 8'hFF);
    smp(2'd0, 8'h08);
    rd(16'h0804, 8'h00);
    rd(16'h0014, 8'h00);
    rd(16'h087E, 8'h00);
    $display("test_idle done");
  endtask : test_idle
  task test_indicators;
    wr(16'h000B, 8'h10);
    wr(16'h000E, 8'h04);
    request(0, 4, 4);
    check("mission", mission_active, 1'b1);
    request(1, 2, 2);
    $display("test_indicators done");
  endtask : test_indicators
  task test_alarm_log;
    smp(2'd0, 8'h08);
    smp(2'd0, 8'h10);
    smp(2'd0, 8'h80);
    sample_counter = 24'hABCDEF;
    smp(2'd0, 8'h09);
    smp(2'd1, 8'h0C);
    check("irq", irq_n, 1'b0);
    rd(16'h0014, 8'h24);
    rd(16'h0804, 8'h02);
    rd(16'h0805, 8'h00);
    rd(16'h0886, 8'h01);
    rd(16'h0220, 8'h56);
    rd(16'h0221, 8'h34);
    rd(16'h0222, 8'h12);
    rd(16'h0223, 8'h02);
    rd(16'h0224, 8'hEF);
    rd(16'h0227, 8'h01);
    request(2, 0, 4);
    $display("test_alarm_log done");
  endtask : test_alarm_log
  // Back-to-back samples: bin 16 saturates, then a 256-reading low run
  task test_long_runs;
    @(negedge clock) sample = {1'b1, 2'd0, 8'h40};
    repeat (65536) @(negedge clock);
    sample = {1'b1, 2'd0, 8'h05};
    repeat (256) @(negedge clock);
    sample = '0;
    rd(16'h0820, 8'hFF);
    rd(16'h0821, 8'hFF);
    rd(16'h022B, 8'hFF);
    rd(16'h022F, 8'h01);
    $display("test_long_runs done");
  endtask : test_long_runs
  task test_mission_end;
    wr(16'h0014, 8'h20);
    rd(16'h0014, 8'h20);
    check("irq clear", irq_n, 1'b1);
    wr(16'h0014, 8'h00);
    check("mission off", mission_active, 1'b0);
    wr(16'h0014, 8'h20);
    check("mission one", mission_active, 1'b0);
    request(0, 4, 4);
    wr(16'h000C, 8'hF0);
    check("mission stop", mission_active, 1'b0);
    $display("test_mission_end done");
  endtask : test_mission_end
  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #320000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    test_idle;
    test_indicators;
    test_alarm_log;
    test_long_runs;
    test_mission_end;
    finish_test;
  end
endmodule : mission_histogram_alarm_log_tb_top
